/* src/afmf_pkg.sv */
// Constants for the access control entry match filter.
// Assumes a 32-bit AXI4-Lite register bus and one switch core clock.
package afmf_pkg;
  // Register byte offsets.
  localparam logic [7:0] OFS_CTRL     = 8'h00;
  localparam logic [7:0] OFS_VID_PROT = 8'h04;
  localparam logic [7:0] OFS_SRC_LO   = 8'h08;
  localparam logic [7:0] OFS_SRC_HI   = 8'h0C;
  localparam logic [7:0] OFS_DST_LO   = 8'h10;
  localparam logic [7:0] OFS_DST_HI   = 8'h14;
  localparam logic [7:0] OFS_SIP      = 8'h18;
  localparam logic [7:0] OFS_SIP_MASK = 8'h1C;
  localparam logic [7:0] OFS_DIP      = 8'h20;
  localparam logic [7:0] OFS_DIP_MASK = 8'h24;
  localparam logic [7:0] OFS_COUNT    = 8'h28;
  localparam logic [7:0] OFS_STATUS   = 8'h2C;
  // Control field positions (low bit of each field); F_PVAL is in the VID/protocol register.
  localparam int F_FTYPE = 0;
  localparam int F_DENY  = 2;
  localparam int F_SRC   = 3;
  localparam int F_DST   = 4;
  localparam int F_VID   = 7;
  localparam int F_PRIEN = 8;
  localparam int F_PRI   = 9;
  localparam int F_PROTO = 12;
  localparam int F_TTL   = 15;
  localparam int F_FRAG  = 17;
  localparam int F_OPT   = 19;
  localparam int F_SIPM  = 21;
  localparam int F_DIPM  = 23;
  localparam int F_PVAL  = 16;
  // Frame type codes, shared by entry setting and parser class.
  localparam logic [1:0] FT_ANY  = 2'h0;
  localparam logic [1:0] FT_ETH  = 2'h1;
  localparam logic [1:0] FT_ARP  = 2'h2;
  localparam logic [1:0] FT_IPV4 = 2'h3;
  // Destination address modes.
  localparam logic [2:0] DM_ANY  = 3'h0;
  localparam logic [2:0] DM_MC   = 3'h1;
  localparam logic [2:0] DM_BC   = 3'h2;
  localparam logic [2:0] DM_UC   = 3'h3;
  localparam logic [2:0] DM_SPEC = 3'h4;
  // Protocol modes and protocol numbers.
  localparam logic [2:0] PM_ANY  = 3'h0;
  localparam logic [2:0] PM_SPEC = 3'h1;
  localparam logic [2:0] PM_ICMP = 3'h2;
  localparam logic [2:0] PM_UDP  = 3'h3;
  localparam logic [2:0] PM_TCP  = 3'h4;
  localparam logic [7:0] PROTO_ICMP = 8'h01;
  localparam logic [7:0] PROTO_TCP  = 8'h06;
  localparam logic [7:0] PROTO_UDP  = 8'h11;
  // Three-way flag modes: TTL zero/non-zero, fragment and option no/yes.
  localparam logic [1:0] TM_ANY = 2'h0;
  localparam logic [1:0] TM_NO  = 2'h1;
  localparam logic [1:0] TM_YES = 2'h2;
  // Address filter modes.
  localparam logic [1:0] AM_ANY  = 2'h0;
  localparam logic [1:0] AM_HOST = 2'h1;
  localparam logic [1:0] AM_NET  = 2'h2;
  // Reset values and bus answers.
  localparam logic [31:0] CTRL_RST = 32'h0000_0000;
  localparam logic [31:0] MASK_RST = 32'hFFFF_FFFF;
  localparam logic [1:0]  RESP_OK  = 2'h0;
  localparam logic [1:0]  RESP_ERR = 2'h2;
endpackage

/* src/afmf_filter.sv */
// One access control entry: AXI4-Lite registers and the match logic.
// Assumes header fields from the ingress parser, valid for one cycle.
`timescale 1ns/1ps
`default_nettype none
module afmf_filter #(
  parameter int CNT_W = 32
) (
  // Clock and reset.
  input  wire  logic        sys_clk,
  input  wire  logic        reset_n,
  // AXI4-Lite write address and data.
  input  wire  logic [7:0]  s_axi_awaddr,
  input  wire  logic        s_axi_awvalid,
  output logic              s_axi_awready,
  input  wire  logic [31:0] s_axi_wdata,
  input  wire  logic [3:0]  s_axi_wstrb,
  input  wire  logic        s_axi_wvalid,
  output logic              s_axi_wready,
  // AXI4-Lite write response.
  output logic [1:0]        s_axi_bresp,
  output logic              s_axi_bvalid,
  input  wire  logic        s_axi_bready,
  // AXI4-Lite read.
  input  wire  logic [7:0]  s_axi_araddr,
  input  wire  logic        s_axi_arvalid,
  output logic              s_axi_arready,
  output logic [31:0]       s_axi_rdata,
  output logic [1:0]        s_axi_rresp,
  output logic              s_axi_rvalid,
  input  wire  logic        s_axi_rready,
  // Header fields from the ingress parser.
  input  wire  logic        hdr_valid,
  input  wire  logic [1:0]  hdr_frame_class,
  input  wire  logic [47:0] hdr_source_hw_address,
  input  wire  logic [47:0] hdr_destination_hw_address,
  input  wire  logic [11:0] hdr_vlan_id,
  input  wire  logic [2:0]  hdr_tag_priority,
  input  wire  logic [7:0]  hdr_protocol,
  input  wire  logic [7:0]  hdr_ttl,
  input  wire  logic        hdr_more_fragments_flag,
  input  wire  logic [12:0] hdr_fragment_position,
  input  wire  logic        hdr_options_flag,
  input  wire  logic [31:0] hdr_source_ipv4,
  input  wire  logic [31:0] hdr_destination_ipv4,
  // Verdict toward the forwarding logic.
  output logic              verdict_valid,
  output logic              verdict_match,
  output logic              verdict_drop,
  output logic              verdict_forward
);

  if (CNT_W < 1 || CNT_W > 32) begin : g_bad_width
    $error("CNT_W must lie between 1 and 32");
  end

  typedef struct packed {
    logic [31:0]      ctrl;
    logic [31:0]      vid_prot;
    logic [47:0]      src_mac;
    logic [47:0]      dst_mac;
    logic [31:0]      source_ipv4_match;
    logic [31:0]      sip_mask;
    logic [31:0]      destination_ipv4_match;
    logic [31:0]      dip_mask;
    logic [CNT_W-1:0] count;
    logic             aw_got;
    logic [7:0]       aw_addr;
    logic             w_got;
    logic [31:0]      w_data;
    logic [3:0]       w_strb;
    logic             awready;
    logic             wready;
    logic             bvalid;
    logic [1:0]       bresp;
    logic             arready;
    logic             rvalid;
    logic [31:0]      rdata;
    logic [1:0]       rresp;
    logic             v_valid;
    logic             v_match;
    logic             v_drop;
    logic             v_fwd;
  } afmf_state_t;

  afmf_state_t st_r;
  afmf_state_t st_nxt;

  // Merges write data into a register under the byte strobes.
  function automatic logic [31:0] afmf_merge(input logic [31:0] old,
                                             input logic [31:0] data,
                                             input logic [3:0]  strb);
    logic [31:0] res;
    res = old;
    for (int i = 0; i < 4; i++) begin
      if (strb[i]) begin
        res[i*8 +: 8] = data[i*8 +: 8];
      end
    end
    return res;
  endfunction

  // Three-way check used by TTL, fragment and option criteria.
  function automatic logic afmf_tri(input logic [1:0] mode,
                                    input logic       flag);
    return (mode == afmf_pkg::TM_ANY) ||
           (mode == afmf_pkg::TM_NO && !flag) ||
           (mode == afmf_pkg::TM_YES && flag);
  endfunction

  // Host or network address check, used for source and destination.
  function automatic logic afmf_addr(input logic [1:0]  mode,
                                     input logic [31:0] frame,
                                     input logic [31:0] cfg,
                                     input logic [31:0] mask);
    return (mode == afmf_pkg::AM_ANY) ||
           (mode == afmf_pkg::AM_HOST && frame == cfg) ||
           (mode == afmf_pkg::AM_NET && (frame & mask) == (cfg & mask));
  endfunction

  logic [1:0]  ftype;
  logic        is_ip;
  logic        type_ok;
  logic        src_ok;
  logic        dst_ok;
  logic        vid_ok;
  logic        pri_ok;
  logic        proto_ok;
  logic        ip_ok;
  logic        hit;
  logic        is_bc;
  logic        is_mc;
  logic [2:0]  dmode;
  logic [2:0]  pmode;
  logic        aw_have;
  logic        w_have;
  logic [7:0]  wa;
  logic [31:0] wd;
  logic [3:0]  ws;
  logic [31:0] rd;
  logic        rd_ok;
  logic        cnt_clr;

  always_comb begin
    st_nxt = st_r;
    ftype  = st_r.ctrl[afmf_pkg::F_FTYPE +: 2];
    dmode  = st_r.ctrl[afmf_pkg::F_DST +: 3];
    pmode  = st_r.ctrl[afmf_pkg::F_PROTO +: 3];
    is_ip  = (hdr_frame_class == afmf_pkg::FT_IPV4);
    type_ok = (ftype == afmf_pkg::FT_ANY) || (ftype == hdr_frame_class);
    src_ok = 1'b1;
    if ((ftype == afmf_pkg::FT_ETH || ftype == afmf_pkg::FT_ARP) &&
        st_r.ctrl[afmf_pkg::F_SRC]) begin
      src_ok = (hdr_source_hw_address == st_r.src_mac);
    end
    is_bc = &hdr_destination_hw_address;
    is_mc = hdr_destination_hw_address[40] && !is_bc;
    unique case (dmode)
      afmf_pkg::DM_MC:   dst_ok = is_mc;
      afmf_pkg::DM_BC:   dst_ok = is_bc;
      afmf_pkg::DM_UC:   dst_ok = !hdr_destination_hw_address[40];
      afmf_pkg::DM_SPEC: dst_ok = (hdr_destination_hw_address == st_r.dst_mac);
      default:           dst_ok = 1'b1;
    endcase
    vid_ok = !st_r.ctrl[afmf_pkg::F_VID] ||
             (hdr_vlan_id == st_r.vid_prot[11:0]);
    pri_ok = !st_r.ctrl[afmf_pkg::F_PRIEN] ||
             (hdr_tag_priority == st_r.ctrl[afmf_pkg::F_PRI +: 3]);
    unique case (pmode)
      afmf_pkg::PM_SPEC: proto_ok = (hdr_protocol ==
                                     st_r.vid_prot[afmf_pkg::F_PVAL +: 8]);
      afmf_pkg::PM_ICMP: proto_ok = (hdr_protocol == afmf_pkg::PROTO_ICMP);
      afmf_pkg::PM_UDP:  proto_ok = (hdr_protocol == afmf_pkg::PROTO_UDP);
      afmf_pkg::PM_TCP:  proto_ok = (hdr_protocol == afmf_pkg::PROTO_TCP);
      default:           proto_ok = 1'b1;
    endcase
    // TTL zero or non-zero; fragment test; options flag
    ip_ok = proto_ok &&
            afmf_tri(st_r.ctrl[afmf_pkg::F_TTL +: 2], hdr_ttl != 8'h00) &&
            afmf_tri(st_r.ctrl[afmf_pkg::F_FRAG +: 2],
                     hdr_more_fragments_flag ||
                     (hdr_fragment_position != 13'h0000)) &&
            afmf_tri(st_r.ctrl[afmf_pkg::F_OPT +: 2], hdr_options_flag);
    ip_ok = ip_ok && afmf_addr(st_r.ctrl[afmf_pkg::F_SIPM +: 2],
                               hdr_source_ipv4, st_r.source_ipv4_match, st_r.sip_mask);
    ip_ok = ip_ok && afmf_addr(st_r.ctrl[afmf_pkg::F_DIPM +: 2],
                               hdr_destination_ipv4, st_r.destination_ipv4_match, st_r.dip_mask);
    if (!is_ip) begin
      ip_ok = (pmode == afmf_pkg::PM_ANY) &&
              (st_r.ctrl[afmf_pkg::F_TTL +: 2] == afmf_pkg::TM_ANY) &&
              (st_r.ctrl[afmf_pkg::F_FRAG +: 2] == afmf_pkg::TM_ANY) &&
              (st_r.ctrl[afmf_pkg::F_OPT +: 2] == afmf_pkg::TM_ANY) &&
              (st_r.ctrl[afmf_pkg::F_SIPM +: 2] == afmf_pkg::AM_ANY) &&
              (st_r.ctrl[afmf_pkg::F_DIPM +: 2] == afmf_pkg::AM_ANY);
    end
    hit = type_ok && src_ok && dst_ok && vid_ok && pri_ok && ip_ok;

    st_nxt.v_valid = hdr_valid;
    st_nxt.v_match = hdr_valid && hit;
    st_nxt.v_drop  = hdr_valid && hit && st_r.ctrl[afmf_pkg::F_DENY];
    st_nxt.v_fwd   = hdr_valid && !(hit && st_r.ctrl[afmf_pkg::F_DENY]);

    // Write channel: address and data may arrive in either order.
    aw_have = st_r.aw_got || (s_axi_awvalid && st_r.awready);
    w_have  = st_r.w_got || (s_axi_wvalid && st_r.wready);
    wa = st_r.aw_got ? st_r.aw_addr : s_axi_awaddr;
    wd = st_r.w_got ? st_r.w_data : s_axi_wdata;
    ws = st_r.w_got ? st_r.w_strb : s_axi_wstrb;
    if (s_axi_awvalid && st_r.awready) begin
      st_nxt.aw_got  = 1'b1;
      st_nxt.aw_addr = s_axi_awaddr;
      st_nxt.awready = 1'b0;
    end
    if (s_axi_wvalid && st_r.wready) begin
      st_nxt.w_got  = 1'b1;
      st_nxt.w_data = s_axi_wdata;
      st_nxt.w_strb = s_axi_wstrb;
      st_nxt.wready = 1'b0;
    end
    cnt_clr = 1'b0;
    if (aw_have && w_have && !st_r.bvalid) begin
      st_nxt.aw_got = 1'b0;
      st_nxt.w_got  = 1'b0;
      st_nxt.bvalid = 1'b1;
      st_nxt.bresp  = afmf_pkg::RESP_OK;
      unique case (wa)
        afmf_pkg::OFS_CTRL:
          st_nxt.ctrl = afmf_merge(st_r.ctrl, wd, ws);
        afmf_pkg::OFS_VID_PROT:
          st_nxt.vid_prot = afmf_merge(st_r.vid_prot, wd, ws);
        afmf_pkg::OFS_SRC_LO:
          st_nxt.src_mac[31:0] = afmf_merge(st_r.src_mac[31:0], wd, ws);
        afmf_pkg::OFS_SRC_HI:
          st_nxt.src_mac[47:32] = 16'(afmf_merge({16'h0000,
                                   st_r.src_mac[47:32]}, wd, ws));
        afmf_pkg::OFS_DST_LO:
          st_nxt.dst_mac[31:0] = afmf_merge(st_r.dst_mac[31:0], wd, ws);
        afmf_pkg::OFS_DST_HI:
          st_nxt.dst_mac[47:32] = 16'(afmf_merge({16'h0000,
                                   st_r.dst_mac[47:32]}, wd, ws));
        afmf_pkg::OFS_SIP:
          st_nxt.source_ipv4_match = afmf_merge(st_r.source_ipv4_match, wd, ws);
        afmf_pkg::OFS_SIP_MASK:
          st_nxt.sip_mask = afmf_merge(st_r.sip_mask, wd, ws);
        afmf_pkg::OFS_DIP:
          st_nxt.destination_ipv4_match = afmf_merge(st_r.destination_ipv4_match, wd, ws);
        afmf_pkg::OFS_DIP_MASK:
          st_nxt.dip_mask = afmf_merge(st_r.dip_mask, wd, ws);
        afmf_pkg::OFS_COUNT:
          cnt_clr = 1'b1;
        afmf_pkg::OFS_STATUS: ;
        default:
          st_nxt.bresp = afmf_pkg::RESP_ERR;
      endcase
    end
    if (st_r.bvalid && s_axi_bready) begin
      st_nxt.bvalid  = 1'b0;
      st_nxt.awready = 1'b1;
      st_nxt.wready  = 1'b1;
    end

    // A match in the cycle of a software clear still counts as one.
    // count matching frames
    if (cnt_clr) begin
      st_nxt.count = (hdr_valid && hit) ? CNT_W'(1) : '0;
    end else if (hdr_valid && hit) begin
      st_nxt.count = st_r.count + CNT_W'(1);
    end

    // Read channel.
    rd_ok = 1'b1;
    unique case (s_axi_araddr)
      afmf_pkg::OFS_CTRL:     rd = st_r.ctrl;
      afmf_pkg::OFS_VID_PROT: rd = st_r.vid_prot;
      afmf_pkg::OFS_SRC_LO:   rd = st_r.src_mac[31:0];
      afmf_pkg::OFS_SRC_HI:   rd = {16'h0000, st_r.src_mac[47:32]};
      afmf_pkg::OFS_DST_LO:   rd = st_r.dst_mac[31:0];
      afmf_pkg::OFS_DST_HI:   rd = {16'h0000, st_r.dst_mac[47:32]};
      afmf_pkg::OFS_SIP:      rd = st_r.source_ipv4_match;
      afmf_pkg::OFS_SIP_MASK: rd = st_r.sip_mask;
      afmf_pkg::OFS_DIP:      rd = st_r.destination_ipv4_match;
      afmf_pkg::OFS_DIP_MASK: rd = st_r.dip_mask;
      afmf_pkg::OFS_COUNT:    rd = 32'(st_r.count);
      afmf_pkg::OFS_STATUS:   rd = {29'h0000_0000, st_r.v_fwd,
                                    st_r.v_drop, st_r.v_match};
      default: begin
        rd    = 32'h0000_0000;
        rd_ok = 1'b0;
      end
    endcase
    if (s_axi_arvalid && st_r.arready) begin
      st_nxt.arready = 1'b0;
      st_nxt.rvalid  = 1'b1;
      st_nxt.rdata   = rd;
      st_nxt.rresp   = rd_ok ? afmf_pkg::RESP_OK : afmf_pkg::RESP_ERR;
    end
    if (st_r.rvalid && s_axi_rready) begin
      st_nxt.rvalid  = 1'b0;
      st_nxt.arready = 1'b1;
    end
  end

  // Masks reset to all ones so network mode starts as an exact compare.
  always_ff @(posedge sys_clk) begin
    if (!reset_n) begin
      st_r          <= '0;
      st_r.ctrl     <= afmf_pkg::CTRL_RST;
      st_r.sip_mask <= afmf_pkg::MASK_RST;
      st_r.dip_mask <= afmf_pkg::MASK_RST;
      st_r.awready  <= 1'b1;
      st_r.wready   <= 1'b1;
      st_r.arready  <= 1'b1;
    end else begin
      st_r <= st_nxt;
    end
  end

  assign s_axi_awready   = st_r.awready;
  assign s_axi_wready    = st_r.wready;
  assign s_axi_bresp     = st_r.bresp;
  assign s_axi_bvalid    = st_r.bvalid;
  assign s_axi_arready   = st_r.arready;
  assign s_axi_rdata     = st_r.rdata;
  assign s_axi_rresp     = st_r.rresp;
  assign s_axi_rvalid    = st_r.rvalid;
  assign verdict_valid   = st_r.v_valid;
  assign verdict_match   = st_r.v_match;
  assign verdict_drop    = st_r.v_drop;
  assign verdict_forward = st_r.v_fwd;

endmodule // afmf_filter
`default_nettype wire

/* tb/afmf_checker.sv */
// Bus and verdict checks for the match filter, bound to its top module.
// Assumes one clock domain and the synchronous active-low reset.
`timescale 1ns/1ps
`default_nettype none
module afmf_checker #(
  parameter int CNT_W = 32
) (
  // Clock and reset.
  input wire logic        sys_clk,
  input wire logic        reset_n,
  // Register bus.
  input wire logic        s_axi_awready,
  input wire logic [1:0]  s_axi_bresp,
  input wire logic        s_axi_bvalid,
  input wire logic        s_axi_bready,
  input wire logic        s_axi_arvalid,
  input wire logic        s_axi_arready,
  input wire logic [31:0] s_axi_rdata,
  input wire logic        s_axi_rvalid,
  input wire logic        s_axi_rready,
  // Header strobe and verdict.
  input wire logic        hdr_valid,
  input wire logic        verdict_valid,
  input wire logic        verdict_match,
  input wire logic        verdict_drop,
  input wire logic        verdict_forward
);
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!reset_n);
  property p_vfol; hdr_valid |=> verdict_valid; endproperty
  a_vfol: assert property (p_vfol) else $error("verdict missing");
  property p_vquiet; !hdr_valid |=> !verdict_valid; endproperty
  a_vquiet: assert property (p_vquiet) else $error("stray verdict");
  property p_drop; verdict_drop |-> verdict_match; endproperty
  a_drop: assert property (p_drop) else $error("drop without match");
  property p_fwd; verdict_valid |-> verdict_forward != verdict_drop; endproperty
  a_fwd: assert property (p_fwd) else $error("forward and drop clash");
  property p_bhold;
    s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp);
  endproperty
  a_bhold: assert property (p_bhold) else $error("write answer dropped");
  property p_rhold;
    s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata);
  endproperty
  a_rhold: assert property (p_rhold) else $error("read answer dropped");
  property p_rfix; s_axi_arvalid && s_axi_arready |=> s_axi_rvalid; endproperty
  a_rfix: assert property (p_rfix) else $error("read answer late");
  property p_rcause;
    $rose(s_axi_rvalid) |-> $past(s_axi_arvalid) && $past(s_axi_arready);
  endproperty
  a_rcause: assert property (p_rcause) else $error("read answer unasked");
  property p_awblk; s_axi_bvalid |-> !s_axi_awready; endproperty
  a_awblk: assert property (p_awblk) else $error("second write accepted");
endmodule // afmf_checker
bind afmf_filter afmf_checker #(.CNT_W(CNT_W)) u_chk (
  .sys_clk(sys_clk), .reset_n(reset_n), .s_axi_awready(s_axi_awready),
  .s_axi_bresp(s_axi_bresp), .s_axi_bvalid(s_axi_bvalid),
  .s_axi_bready(s_axi_bready), .s_axi_arvalid(s_axi_arvalid),
  .s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata),
  .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready),
  .hdr_valid(hdr_valid), .verdict_valid(verdict_valid),
  .verdict_match(verdict_match), .verdict_drop(verdict_drop),
  .verdict_forward(verdict_forward)
);
`default_nettype wire

/* tb/afmf_parser_model.sv */
// Ingress parser stand-in: presents one header per send request.
// Assumes the bench packs all header fields into one vector.
`timescale 1ns/1ps
`default_nettype none
module afmf_parser_model (
  // Clock and reset.
  input  wire logic         sys_clk,
  input  wire logic         reset_n,
  // Request from the bench.
  input  wire logic         send,
  input  wire logic [207:0] hdr_in,
  // Header toward the filter.
  output logic              hdr_valid,
  output logic [207:0]      hdr_out
);
  // Fields toggle between headers so stale values never pass as valid.
  always_ff @(posedge sys_clk) begin
    if (!reset_n) begin
      hdr_valid <= 1'b0;
      hdr_out   <= '0;
    end else begin
      hdr_valid <= send;
      hdr_out   <= send ? hdr_in : ~hdr_out;
    end
  end
endmodule // afmf_parser_model
`default_nettype wire

/* tb/tb_acl_frame_match_filter.sv */
// Self-checking bench for the access control entry match filter.
// Assumes the parser model and the bound checker are compiled before it.
`timescale 1ns/1ps
`default_nettype none
`define CHK(a, b) begin compares++; if ((a) !== (b)) begin err_count++; \
  $display("[FAIL] %0t got %0h exp %0h", $time, a, b); end end
module tb_acl_frame_match_filter;
  localparam logic [1:0]  OK    = afmf_pkg::RESP_OK;
  localparam logic [47:0] BCAST = 48'hFFFF_FFFF_FFFF;
  logic         sys_clk = 1'b0;
  logic         reset_n = 1'b0;
  logic [7:0]   awaddr = 8'h00;
  logic [7:0]   araddr = 8'h00;
  logic [31:0]  wdata = 32'h0000_0000;
  logic         awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0;
  logic         arvalid = 1'b0, rready = 1'b0, send = 1'b0;
  logic [207:0] hv = '0;
  wire logic    awready, wready, bvalid, arready, rvalid, hval;
  wire logic    vv, vm, vd, vf;
  wire logic [1:0]   bresp, rresp;
  wire logic [31:0]  rdata;
  wire logic [207:0] ho;
  logic [31:0]  ctrl, vp, sipv, sipm, dipv, dipm, source_ipv4_match, destination_ipv4_match, k, d, cnt;
  logic [47:0]  src, dst, source_hw_address, destination_hw_address;
  logic [1:0]   cls, r;
  logic [11:0]  vid;
  logic [12:0]  frag;
  logic [7:0]   proto, ttl;
  logic [2:0]   pri;
  logic         ip, mf, opt, em;
  integer       seed = 47213;
  int           err_count = 0;
  int           compares = 0;
  int           cyc = 0;

  always #12.5 sys_clk = ~sys_clk;

  afmf_parser_model u_parser (.sys_clk(sys_clk), .reset_n(reset_n),
    .send(send), .hdr_in(hv), .hdr_valid(hval), .hdr_out(ho));

  afmf_filter #(.CNT_W(32)) dut (.sys_clk(sys_clk), .reset_n(reset_n),
    .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
    .s_axi_wdata(wdata), .s_axi_wstrb(4'hF), .s_axi_wvalid(wvalid),
    .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid),
    .s_axi_bready(bready), .s_axi_araddr(araddr), .s_axi_arvalid(arvalid),
    .s_axi_arready(arready), .s_axi_rdata(rdata), .s_axi_rresp(rresp),
    .s_axi_rvalid(rvalid), .s_axi_rready(rready), .hdr_valid(hval),
    .hdr_frame_class(ho[207:206]), .hdr_source_hw_address(ho[205:158]),
    .hdr_destination_hw_address(ho[157:110]), .hdr_vlan_id(ho[109:98]),
    .hdr_tag_priority(ho[97:95]), .hdr_protocol(ho[94:87]),
    .hdr_ttl(ho[86:79]), .hdr_more_fragments_flag(ho[78]),
    .hdr_fragment_position(ho[77:65]), .hdr_options_flag(ho[64]),
    .hdr_source_ipv4(ho[63:32]), .hdr_destination_ipv4(ho[31:0]),
    .verdict_valid(vv), .verdict_match(vm), .verdict_drop(vd),
    .verdict_forward(vf));

  task automatic final_report();
    if (err_count == 0 && compares > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask

  always @(posedge sys_clk) begin
    cyc++;
    if (cyc == 60000) begin
      err_count++;
      final_report();
    end
  end

  // Answer ready goes up with the request, so no answer cycle is wasted.
  task automatic wr(input logic [7:0] a, input logic [31:0] v,
                    output logic [1:0] rs);
    logic done;
    done = 1'b0;
    @(posedge sys_clk);
    awaddr <= a;
    wdata <= v;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    while (!done) begin
      @(posedge sys_clk);
      if (awready && awvalid) awvalid <= 1'b0;
      if (wready && wvalid) wvalid <= 1'b0;
      if (bvalid && bready) begin
        rs = bresp;
        done = 1'b1;
      end
    end
    bready <= 1'b0;
  endtask

  task automatic chk_rd(input logic [7:0] a, input logic [31:0] ev,
                        input logic [1:0] er);
    logic done;
    done = 1'b0;
    @(posedge sys_clk);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    while (!done) begin
      @(posedge sys_clk);
      if (arready && arvalid) arvalid <= 1'b0;
      if (rvalid && rready) begin
        `CHK(rdata, ev)
        `CHK(rresp, er)
        done = 1'b1;
      end
    end
    rready <= 1'b0;
  endtask

  task automatic cfg();
    logic [31:0] v [10];
    v = '{ctrl, vp, src[31:0], {16'h0000, src[47:32]}, dst[31:0],
          {16'h0000, dst[47:32]}, sipv, sipm, dipv, dipm};
    for (int i = 0; i < 10; i++) begin
      wr(8'(4 * i), v[i], r);
      `CHK(r, OK)
    end
  endtask

  task automatic frame();
    @(posedge sys_clk);
    send <= 1'b1;
    hv <= {cls, source_hw_address, destination_hw_address, vid, pri, proto, ttl, mf, frag, opt, source_ipv4_match, destination_ipv4_match};
    @(posedge sys_clk);
    send <= 1'b0;
    @(posedge sys_clk);
    #1;
  endtask

  function automatic logic tri_ok(input logic [1:0] m, input logic f);
    return m == 2'h0 || (ip && (m == 2'h1 ? !f : m == 2'h2 && f));
  endfunction

  function automatic logic addr_ok(input logic [1:0] m,
                                   input logic [31:0] a, c, msk);
    return m == 2'h0 || (ip && (m == 2'h1 ? a == c :
                                m == 2'h2 && (a & msk) == (c & msk)));
  endfunction

  function automatic logic exp_match();
    logic ok;
    logic [7:0] pn;
    ok = ctrl[1:0] == 2'h0 || ctrl[1:0] == cls;
    if (ctrl[3] && (ctrl[1:0] == 2'h1 || ctrl[1:0] == 2'h2)) ok &= source_hw_address == src;
    case (ctrl[6:4])
      3'h1: ok &= destination_hw_address[40] && destination_hw_address != BCAST;
      3'h2: ok &= destination_hw_address == BCAST;
      3'h3: ok &= !destination_hw_address[40];
      3'h4: ok &= destination_hw_address == dst;
      default: ok &= 1'b1;
    endcase
    if (ctrl[7]) ok &= vid == vp[11:0];
    if (ctrl[8]) ok &= pri == ctrl[11:9];
    pn = ctrl[14:12] == 3'h1 ? vp[23:16] : ctrl[14:12] == 3'h2 ? 8'h01 :
         ctrl[14:12] == 3'h3 ? 8'h11 : 8'h06;
    if (ctrl[14:12] != 3'h0) ok &= ip && proto == pn;
    ok &= tri_ok(ctrl[16:15], ttl != 8'h00);
    ok &= tri_ok(ctrl[18:17], mf || frag != 13'h0000);
    ok &= tri_ok(ctrl[20:19], opt);
    ok &= addr_ok(ctrl[22:21], source_ipv4_match, sipv, sipm);
    ok &= addr_ok(ctrl[24:23], destination_ipv4_match, dipv, dipm);
    return ok;
  endfunction

  initial begin
    repeat (4) @(posedge sys_clk);
    reset_n <= 1'b1;
    chk_rd(afmf_pkg::OFS_CTRL, afmf_pkg::CTRL_RST, OK);
    chk_rd(afmf_pkg::OFS_SIP_MASK, afmf_pkg::MASK_RST, OK);
    chk_rd(afmf_pkg::OFS_DIP_MASK, afmf_pkg::MASK_RST, OK);
    chk_rd(afmf_pkg::OFS_COUNT, 32'h0000_0000, OK);
    chk_rd(8'h30, 32'h0000_0000, afmf_pkg::RESP_ERR);
    wr(8'h30, 32'h1234_5678, r);
    `CHK(r, afmf_pkg::RESP_ERR)
    cnt = 32'h0000_0000;
    for (int n = 0; n < 300; n++) begin
      ctrl = $random(seed) & $random(seed) & 32'h01FF_FFFF;
      if (ctrl[14:12] > 3'h4) ctrl[14:12] = 3'h0;
      vp = $random(seed) & 32'h00FF_0FFF;
      src = 48'({$random(seed), $random(seed)});
      dst = 48'({$random(seed), $random(seed)});
      sipv = $random(seed);
      sipm = $random(seed);
      dipv = $random(seed);
      dipm = $random(seed);
      cfg();
      k = $random(seed);
      d = $random(seed);
      cls = (k[2:0] == 3'h0 || ctrl[1:0] == 2'h0) ? k[31:30] : ctrl[1:0];
      ip = cls == 2'h3;
      source_hw_address = k[3] ? src : {d[15:0], d};
      // Corner classes: own address, broadcast, group and individual.
      case (k[5:4])
        2'h0: destination_hw_address = dst;
        2'h1: destination_hw_address = BCAST;
        2'h2: destination_hw_address = {d[15:0], d} | 48'h0100_0000_0000;
        default: destination_hw_address = {d[15:0], d} & ~48'h0100_0000_0000;
      endcase
      vid = k[6] ? vp[11:0] : d[27:16];
      pri = k[7] ? ctrl[11:9] : k[10:8];
      proto = k[12] ? (k[11] ? 8'h11 : 8'h06) : (k[11] ? 8'h01 : vp[23:16]);
      ttl = k[13] ? 8'h00 : {k[31:25], 1'b1};
      mf = k[14];
      frag = k[15] ? 13'h0000 : (k[16] ? 13'h0001 : k[29:17]);
      opt = k[17];
      source_ipv4_match = k[18] ? sipv : sipv ^ (k[19] ? d : d & ~sipm);
      destination_ipv4_match = k[20] ? dipv : dipv ^ (k[21] ? d : d & ~dipm);
      em = exp_match();
      frame();
      `CHK(vv, 1'b1)
      `CHK(vm, em)
      `CHK(vd, em & ctrl[2])
      `CHK(vf, ~(em & ctrl[2]))
      if (em) cnt = cnt + 32'h0000_0001;
    end
    chk_rd(afmf_pkg::OFS_COUNT, cnt, OK);
    wr(afmf_pkg::OFS_COUNT, k, r);
    chk_rd(afmf_pkg::OFS_COUNT, 32'h0000_0000, OK);
    final_report();
  end
endmodule // tb_acl_frame_match_filter
`default_nettype wire
